//--- src/ltil_pkg.sv
`default_nettype none
package ltil_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_RAW_STATUS    = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_MASKED_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET    = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR  = 5'h0c;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TRAP_BIT    = 2;
  localparam logic        RST_FLAG    = 1'b0;
  localparam logic        RST_ENABLE  = 1'b0;
  localparam logic [31:0] RST_RDATA   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

//--- src/ltil_top.sv
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RL1) Trap event always sets raw flag.
// (RL2) Writing one to raw clears both flags.
// (RL3) Masked flag sets only while enabled.
// (RL4) Writing one to masked clears both flags.
// (RL5) Set write enables; both enable bits read one.
// (RL6) Clear write disables; both enable bits read zero.
// (RL7) Set and clear together leave it disabled.
// (RL8) All other bits read as zero.
// (RL9) Interrupt output follows the masked flag.
module ltil_top (
  // Clock and reset.
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Event from the access checker.
  input  wire logic                       trap_event,
  // Write address channel.
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [ltil_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  // Write data channel.
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  // Write response channel.
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  // Read address channel.
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [ltil_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  // Read data channel.
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  // Interrupt request.
  output logic                            irq
);
  import ltil_pkg::*;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic              awready_ff, nxt_awready;
  logic              wready_ff,  nxt_wready;
  logic              aw_held_ff, nxt_aw_held;
  logic              w_held_ff,  nxt_w_held;
  logic [ADDR_W-1:0] waddr_ff,   nxt_waddr;
  logic [31:0]       wdata_ff,   nxt_wdata;
  logic              wstrb0_ff,  nxt_wstrb0;
  logic              bvalid_ff,  nxt_bvalid;
  logic [1:0]        bresp_ff,   nxt_bresp;
  logic              do_write;
  logic              wr_one;
  logic              wr_raw, wr_masked, wr_set, wr_clr;
  logic              wmapped;

  // Address and data are caught separately, so either may come first.
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb0  = wstrb0_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    do_write    = aw_held_ff && w_held_ff && !bvalid_ff;
    wmapped     = (waddr_ff[ADDR_W-1:2] == OFS_RAW_STATUS[ADDR_W-1:2])
               || (waddr_ff[ADDR_W-1:2] == OFS_MASKED_STATUS[ADDR_W-1:2])
               || (waddr_ff[ADDR_W-1:2] == OFS_ENABLE_SET[ADDR_W-1:2])
               || (waddr_ff[ADDR_W-1:2] == OFS_ENABLE_CLEAR[ADDR_W-1:2]);
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    // Holding off new beats while a response waits keeps one write in flight.
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready  = !nxt_w_held && !nxt_bvalid;
  end

  // Only byte lane 0 carries the trap bit; other lanes are ignored.
  assign wr_one    = do_write && wstrb0_ff && wdata_ff[TRAP_BIT];
  assign wr_raw    = wr_one && (waddr_ff[ADDR_W-1:2] == OFS_RAW_STATUS[ADDR_W-1:2]);
  assign wr_masked = wr_one && (waddr_ff[ADDR_W-1:2] == OFS_MASKED_STATUS[ADDR_W-1:2]);
  assign wr_set    = wr_one && (waddr_ff[ADDR_W-1:2] == OFS_ENABLE_SET[ADDR_W-1:2]);
  assign wr_clr    = wr_one && (waddr_ff[ADDR_W-1:2] == OFS_ENABLE_CLEAR[ADDR_W-1:2]);

  // Write path registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= RST_RDATA;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb0_ff  <= nxt_wstrb0;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
    end
  end

  // ----------------------------------------------------------------
  // Trap flags and enable
  // ----------------------------------------------------------------
  logic raw_ff,    nxt_raw;
  logic masked_ff, nxt_masked;
  logic en_ff,     nxt_en;
  logic irq_ff,    nxt_irq;
  logic clr_flags;

  // A new event in the clearing cycle wins, so no trap is ever lost.
  always_comb begin
    clr_flags  = wr_raw || wr_masked;                               // RL2 RL4
    nxt_raw    = (raw_ff && !clr_flags) || trap_event;              // RL1 RL2
    nxt_masked = (masked_ff && !clr_flags) || (trap_event && en_ff); // RL3 RL4
    nxt_en     = en_ff;
    if (wr_set && wr_clr) begin
      nxt_en = 1'b0;                                                // RL7
    end else if (wr_set) begin
      nxt_en = 1'b1;                                                // RL5
    end else if (wr_clr) begin
      nxt_en = 1'b0;                                                // RL6
    end
    nxt_irq = nxt_masked;                                           // RL9
  end

  // Flag registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_ff    <= RST_FLAG;
      masked_ff <= RST_FLAG;
      en_ff     <= RST_ENABLE;
      irq_ff    <= RST_FLAG;
    end else begin
      raw_ff    <= nxt_raw;
      masked_ff <= nxt_masked;
      en_ff     <= nxt_en;
      irq_ff    <= nxt_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff,  nxt_rvalid;
  logic [31:0] rdata_ff,   nxt_rdata;
  logic [1:0]  rresp_ff,   nxt_rresp;

  // Data is sampled when the address is taken and then held stable.
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = RST_RDATA;                                       // RL8
      nxt_rresp  = RESP_OKAY;
      unique case (s_axi_araddr[ADDR_W-1:2])
        OFS_RAW_STATUS[ADDR_W-1:2]:    nxt_rdata[TRAP_BIT] = raw_ff;
        OFS_MASKED_STATUS[ADDR_W-1:2]: nxt_rdata[TRAP_BIT] = masked_ff;
        OFS_ENABLE_SET[ADDR_W-1:2]:    nxt_rdata[TRAP_BIT] = en_ff; // RL5 RL6
        OFS_ENABLE_CLEAR[ADDR_W-1:2]:  nxt_rdata[TRAP_BIT] = en_ff; // RL5 RL6
        default:                       nxt_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  // Read path registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= RST_RDATA;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign irq           = irq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence write_go_s;
    do_write && wr_one;
  endsequence

  sequence flags_gone_s;
    !raw_ff && !masked_ff && !irq_ff;
  endsequence

  sequence read_take_s;
    s_axi_arvalid && arready_ff;
  endsequence

  raw_set_a: assert property (trap_event |=> raw_ff) // RL1
    else $error("raw flag missed an event");

  raw_clear_a: assert property (write_go_s ##0 (wr_raw && !trap_event) |=> flags_gone_s) // RL2
    else $error("raw write did not clear flags");

  mask_set_a: assert property (trap_event && en_ff |=> masked_ff ##0 irq_ff) // RL3
    else $error("masked flag missed an enabled event");

  mask_quiet_a: assert property (!$past(masked_ff) && !$past(en_ff) |-> !masked_ff) // RL3
    else $error("masked flag set while disabled");

  mask_clear_a: assert property (write_go_s ##0 (wr_masked && !trap_event) |=> flags_gone_s) // RL4
    else $error("masked write did not clear flags");

  enable_set_a: assert property (wr_set && !wr_clr |=> en_ff[*2]) // RL5
    else $error("enable set write failed");

  enable_clear_a: assert property (wr_clr |=> !en_ff) // RL6 RL7
    else $error("enable clear write failed");

  rsvd_zero_a: assert property (rvalid_ff |-> rdata_ff[31:3] == 29'h0 && rdata_ff[1:0] == 2'h0) // RL8
    else $error("reserved read bits not zero");

  irq_follow_a: assert property (irq_ff == masked_ff) // RL9
    else $error("interrupt does not follow masked flag");

  irq_cause_a: assert property (irq_ff |-> $past(en_ff) || $past(irq_ff)) // RL3 RL9
    else $error("interrupt rose while disabled");

  wr_resp_a: assert property (do_write |=> bvalid_ff ##0 !awready_ff ##0 !wready_ff)
    else $error("write response missing");

  // A refused write must leave the enable alone and answer with an error.
  unmapped_wr_a: assert property (do_write && !wmapped |=> bresp_ff == RESP_SLVERR && $stable(en_ff))
    else $error("unmapped write was not refused");

  // Flags fall only on a clear write, and the enable moves only on a write.
  raw_keep_a: assert property (raw_ff && !clr_flags |=> raw_ff) // RL1 RL2
    else $error("raw flag dropped without a clear");

  masked_keep_a: assert property (masked_ff && !clr_flags |=> masked_ff) // RL3 RL4
    else $error("masked flag dropped without a clear");

  en_hold_a: assert property (!wr_set && !wr_clr |=> $stable(en_ff)) // RL5 RL6
    else $error("enable changed without a write");

  // Read data is a snapshot of the flag at the address handshake.
  rd_raw_a: assert property (read_take_s ##0 (s_axi_araddr[ADDR_W-1:2] == OFS_RAW_STATUS[ADDR_W-1:2]) // RL1
    |=> rdata_ff[TRAP_BIT] == $past(raw_ff))
    else $error("raw read does not show raw flag");

  rd_masked_a: assert property (read_take_s ##0 (s_axi_araddr[ADDR_W-1:2] == OFS_MASKED_STATUS[ADDR_W-1:2]) // RL3
    |=> rdata_ff[TRAP_BIT] == $past(masked_ff))
    else $error("masked read does not show masked flag");

endmodule
`default_nettype wire

//--- verif/tb_line_trap_interrupt_logic.sv
`timescale 1ns/1ps
`default_nettype none

module tb_line_trap_interrupt_logic;
  import ltil_pkg::*;

  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic              aclk, aresetn, trap_event, irq;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb, wr_strb;
  logic [1:0]        bresp, rresp;
  int                n_errors, num_checks, cycles;

  ltil_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .trap_event(trap_event),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // The whole run needs well under a thousand cycles, so 5000 means a hang.
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Counts cycles and ends the run as a failure on a hang.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the verdict once and ends the run.
  task automatic print_verdict();
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Counts one comparison and reports it if it does not match.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data are offered together; each is dropped once taken.
  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= wr_strb;
    bready  <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (awready && !aw_done) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_done) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // The address is dropped once taken; data and answer are taken together.
  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_done;
    a_done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (arready && !a_done) begin
        a_done = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // A write that must be accepted with an okay answer.
  task automatic wr_ok(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // A read that must answer okay with the expected word.
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    chk(what, exp, d);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // One-cycle event, then one edge so the flag update has landed.
  task automatic pulse_trap();
    @(posedge aclk);
    trap_event <= 1'b1;
    @(posedge aclk);
    trap_event <= 1'b0;
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // All four registers read zero out of reset, reserved bits included.
  task automatic t_reset();
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("raw", OFS_RAW_STATUS, 32'h0);
    rd_chk("masked", OFS_MASKED_STATUS, 32'h0);
    rd_chk("en_set", OFS_ENABLE_SET, 32'h0);
    rd_chk("en_clr", OFS_ENABLE_CLEAR, 32'h0);
  endtask

  // Event while disabled sets only the raw flag; a zero or a write with lane 0 off keeps it.
  task automatic t_disabled_event();
    pulse_trap();
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("raw", OFS_RAW_STATUS, 32'h4);
    rd_chk("masked", OFS_MASKED_STATUS, 32'h0);
    wr_ok(OFS_RAW_STATUS, 32'hffff_fffb);
    rd_chk("raw", OFS_RAW_STATUS, 32'h4);
    wr_strb = 4'he;
    wr_ok(OFS_RAW_STATUS, 32'h4);
    wr_strb = 4'hf;
    rd_chk("raw_lane", OFS_RAW_STATUS, 32'h4);
    wr_ok(OFS_RAW_STATUS, 32'h4);
    rd_chk("raw", OFS_RAW_STATUS, 32'h0);
  endtask

  // Enabling, then an event, then clearing through the masked register.
  task automatic t_enabled_event();
    wr_ok(OFS_ENABLE_SET, 32'hffff_fffb);
    rd_chk("en_set", OFS_ENABLE_SET, 32'h0);
    wr_ok(OFS_ENABLE_SET, 32'hffff_ffff);
    rd_chk("en_set", OFS_ENABLE_SET, 32'h4);
    rd_chk("en_clr", OFS_ENABLE_CLEAR, 32'h4);
    pulse_trap();
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("masked", OFS_MASKED_STATUS, 32'h4);
    rd_chk("raw", OFS_RAW_STATUS, 32'h4);
    wr_ok(OFS_MASKED_STATUS, 32'h0);
    rd_chk("masked", OFS_MASKED_STATUS, 32'h4);
    wr_ok(OFS_MASKED_STATUS, 32'h4);
    rd_chk("masked", OFS_MASKED_STATUS, 32'h0);
    rd_chk("raw", OFS_RAW_STATUS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // Disabling, then an event must not reach the masked flag.
  task automatic t_disable();
    wr_ok(OFS_ENABLE_CLEAR, 32'hffff_fffb);
    rd_chk("en_clr", OFS_ENABLE_CLEAR, 32'h4);
    wr_ok(OFS_ENABLE_CLEAR, 32'h4);
    rd_chk("en_set", OFS_ENABLE_SET, 32'h0);
    rd_chk("en_clr", OFS_ENABLE_CLEAR, 32'h0);
    pulse_trap();
    rd_chk("masked", OFS_MASKED_STATUS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr_ok(OFS_RAW_STATUS, 32'h4);
  endtask

  // An unmapped word is refused with an error and reads zero.
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(5'h10, 32'hffff_ffff, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_read(5'h14, d, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    rd_chk("raw", OFS_RAW_STATUS, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors   = 0;
    num_checks = 0;
    cycles     = 0;
    aresetn    = 1'b0;
    trap_event = 1'b0;
    awvalid    = 1'b0;
    awaddr     = '0;
    wvalid     = 1'b0;
    wdata      = '0;
    wstrb      = 4'h0;
    wr_strb    = 4'hf;
    bready     = 1'b0;
    arvalid    = 1'b0;
    araddr     = '0;
    rready     = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_disabled_event();
    t_enabled_event();
    t_disable();
    t_unmapped();
    print_verdict();
  end

endmodule
`default_nettype wire
